//--- rtl/acalt_axis_correct.v
// One axis of offset and gain correction ahead of the extended output registers
`timescale 1ns/100ps
module acalt_axis_correct
(
    input  wire               clk,            // System clock
    input  wire               reset_n,        // Async reset, active low
    input  wire               raw_valid,      // Raw sample strobe
    input  wire signed [15:0] raw_value,      // Raw acceleration result
    input  wire signed [14:0] offset_value,   // Signed calibration offset
    input  wire        [8:0]  gain_value,     // Unsigned gain, 256 = unity
    output reg                out_valid,      // Corrected sample strobe
    output reg  signed [15:0] out_value       // Corrected result
);

    // Offset added first, gain applied afterwards, both in one stage
    wire signed [16:0] sum      = {raw_value[15], raw_value} + {{2{offset_value[14]}}, offset_value};
    wire signed [26:0] product  = sum * $signed({1'b0, gain_value});
    wire signed [18:0] scaled   = product[26:8];
    reg  signed [15:0] next_out;            // Saturated result

    // Clamp to 16 bits so a large trim cannot wrap the sign
    always @*
    begin
        if (scaled > 19'sh07FFF)
            next_out = 16'h7FFF;
        else if (scaled < -19'sh08000)
            next_out = 16'h8000;
        else
            next_out = scaled[15:0];
    end

    // Register the corrected sample
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out_valid <= 1'b0;
            out_value <= 16'h0000;
        end
        else
        begin
            out_valid <= raw_valid;                          // [R4]
            if (raw_valid)
                out_value <= next_out;                       // [R4]
        end
    end

endmodule // acalt_axis_correct

//--- rtl/acalt_defs.vh
// Offsets, field positions, reset values and counts for the calibration/trigger register bank
`ifndef ACALT_DEFS_VH
`define ACALT_DEFS_VH

// Register offsets (8-bit register address space)
`define ACALT_ADDR_MODE_CTRL    8'h10
`define ACALT_ADDR_STARTUP_TWO  8'h28
`define ACALT_ADDR_SAMPLE_COUNT 8'h29
`define ACALT_ADDR_X_OFF_LOW    8'h2A
`define ACALT_ADDR_X_OFF_HIGH   8'h2B
`define ACALT_ADDR_Y_OFF_LOW    8'h2C
`define ACALT_ADDR_Y_OFF_HIGH   8'h2D
`define ACALT_ADDR_Z_OFF_LOW    8'h2E
`define ACALT_ADDR_Z_OFF_HIGH   8'h2F
`define ACALT_ADDR_X_GAIN_LOW   8'h30
`define ACALT_ADDR_Y_GAIN_LOW   8'h31
`define ACALT_ADDR_Z_GAIN_LOW   8'h32

// Field positions
`define ACALT_MODE_MSB          2
`define ACALT_MODE_LSB          0
`define ACALT_OFFH_GAIN_BIT     7
`define ACALT_OFFH_OFF_MSB      6

// Reset values
`define ACALT_RST_STARTUP_TWO   8'h00
`define ACALT_RST_SAMPLE_COUNT  8'h00
`define ACALT_RST_MODE          3'h0

// Mode encodings of the operating mode field
`define ACALT_MODE_TRIGGER      3'h6

// Sample count meaning
`define ACALT_COUNT_ENDLESS     8'hFF
`define ACALT_COUNT_NONE        8'h00

// Offset result saturation limits for the corrected 16-bit value
`define ACALT_SAT_MAX           17'sh07FFF
`define ACALT_SAT_MIN           17'sh18000

`endif

//--- rtl/acalt_regs.v
// Calibration and one-shot trigger register bank with per-axis correction
`timescale 1ns/100ps
`include "acalt_defs.vh"

// Function
// (R1) Software writes zero to startup register first
// (R2) Capture exactly the counted samples, 1 to 254
// (R3) Count 255 samples until mode changes
// (R4) Add signed 15-bit offset before extended output
// (R5) Offsets load factory trim; writes replace it
// (R6) Low register offset 7:0, high 14:8
// (R7) Nine-bit gain: bit 8 in high bit 7
// (R8) Software updates shared registers by read-modify-write
// (R9) Z gain low byte own register, bit8 shared
// (R10) Mode field is bits 2:0 of mode
module acalt_regs
(
    input  wire        clk,             // System clock
    input  wire        reset_n,         // Async reset, active low
    input  wire        reg_wr,          // Register write strobe from the serial port
    input  wire        reg_rd,          // Register read strobe from the serial port
    input  wire [7:0]  reg_addr,        // Register address
    input  wire [7:0]  reg_wdata,       // Write data
    input  wire        trim_load,       // Factory trim load strobe
    input  wire [71:0] trim_data,       // Per-axis trim {gain9,offset15} x3, X lowest
    input  wire        sample_tick,     // Sample-rate tick from the engine
    input  wire        raw_valid,       // Raw sample strobe, all axes
    input  wire [47:0] raw_xyz,         // Raw results {z,y,x}
    output reg  [7:0]  reg_rdata,       // Read data
    output reg         reg_rvalid,      // Read data valid
    output reg  [2:0]  operating_mode_field, // Current mode
    output reg  [7:0]  startup_config_two,   // Startup register content
    output reg         sample_req,      // One-shot capture pulse
    output reg         trigger_busy,    // One-shot run in progress
    output reg         ext_valid,       // Corrected sample strobe
    output reg  [47:0] extended_output_regs  // Corrected results {z,y,x}
);

    reg  [7:0]  oneshot_sample_count;   // Samples per trigger
    reg  [14:0] offset_value [0:2];     // Per-axis offset, index 0=X 1=Y 2=Z
    reg  [8:0]  gain_value   [0:2];     // Per-axis gain
    reg  [7:0]  next_rdata;             // Read mux output
    wire        seq_req;                // Sequencer capture pulse
    wire        seq_busy;               // Sequencer busy level
    wire [2:0]  axis_valid;             // Corrected strobes per axis
    wire [47:0] axis_out;               // Corrected values per axis

    // Register map seen by the serial port
    //   0x10  mode control, bits 2:0 kept
    //   0x28  startup register, stored as written
    //   0x29  one-shot sample count
    //   0x2A  X offset bits 7:0
    //   0x2B  X gain bit 8, X offset bits 14:8
    //   0x2C  Y offset bits 7:0
    //   0x2D  Y gain bit 8, Y offset bits 14:8
    //   0x2E  Z offset bits 7:0
    //   0x2F  Z gain bit 8, Z offset bits 14:8
    //   0x30  X gain bits 7:0
    //   0x31  Y gain bits 7:0
    //   0x32  Z gain bits 7:0
    // Any other address ignores writes and reads back zero.
    // Calibration bytes read back although the host need only write
    // them; without that a read-modify-write of a shared byte is blind.
    // Offsets are signed two's complement; gains are unsigned with
    // 256 standing for unity.

    // Address to axis index for the low offset registers, 3 = none
    function [1:0] off_low_axis;
        input [7:0] a;
        begin
            case (a)
                `ACALT_ADDR_X_OFF_LOW: off_low_axis = 2'd0;
                `ACALT_ADDR_Y_OFF_LOW: off_low_axis = 2'd1;
                `ACALT_ADDR_Z_OFF_LOW: off_low_axis = 2'd2;
                default:               off_low_axis = 2'd3;
            endcase
        end
    endfunction

    // Address to axis index for the high offset registers
    function [1:0] off_high_axis;
        input [7:0] a;
        begin
            case (a)
                `ACALT_ADDR_X_OFF_HIGH: off_high_axis = 2'd0;
                `ACALT_ADDR_Y_OFF_HIGH: off_high_axis = 2'd1;
                `ACALT_ADDR_Z_OFF_HIGH: off_high_axis = 2'd2;
                default:                off_high_axis = 2'd3;
            endcase
        end
    endfunction

    // Address to axis index for the gain low byte registers
    function [1:0] gain_axis;
        input [7:0] a;
        begin
            case (a)
                `ACALT_ADDR_X_GAIN_LOW: gain_axis = 2'd0;
                `ACALT_ADDR_Y_GAIN_LOW: gain_axis = 2'd1;
                `ACALT_ADDR_Z_GAIN_LOW: gain_axis = 2'd2;
                default:                gain_axis = 2'd3;
            endcase
        end
    endfunction

    // Plain control registers; startup register holds whatever is written,
    // since keeping it zero is the host's duty
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            startup_config_two   <= `ACALT_RST_STARTUP_TWO;   // [R1]
            oneshot_sample_count <= `ACALT_RST_SAMPLE_COUNT;
            operating_mode_field <= `ACALT_RST_MODE;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `ACALT_ADDR_STARTUP_TWO:
                begin
                    // Kept as written; writing zero is the host's duty
                    startup_config_two <= reg_wdata;                 // [R1]
                end
                `ACALT_ADDR_SAMPLE_COUNT:
                begin
                    // Read by the sequencer only when a run starts
                    oneshot_sample_count <= reg_wdata;               // [R2]
                end
                `ACALT_ADDR_MODE_CTRL:
                begin
                    // Upper bits of the mode byte are not stored
                    operating_mode_field <= reg_wdata[`ACALT_MODE_MSB:`ACALT_MODE_LSB]; // [R10]
                end
                default:
                begin
                    // Other addresses belong to the calibration array or elsewhere
                end
            endcase
        end
    end

    // Calibration array per axis: trim load wins over a same-cycle write
    // so a forced reload always leaves the factory value in place
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_cal
            always @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    // Zero until the factory trim load arrives after power-on
                    offset_value[g] <= 15'h0000;
                    gain_value[g]   <= 9'h000;
                end
                else if (trim_load)
                begin
                    offset_value[g] <= trim_data[g*24 +: 15];       // [R5]
                    gain_value[g]   <= trim_data[g*24+15 +: 9];     // [R5]
                end
                else if (reg_wr)
                begin
                    // Low byte: offset bits 7:0
                    if (off_low_axis(reg_addr) == g)
                    begin
                        offset_value[g][7:0] <= reg_wdata;          // [R6]
                    end
                    // Shared byte: gain bit 8 over offset bits 14:8
                    if (off_high_axis(reg_addr) == g)
                    begin
                        offset_value[g][14:8] <= reg_wdata[`ACALT_OFFH_OFF_MSB:0]; // [R6]
                        gain_value[g][8]      <= reg_wdata[`ACALT_OFFH_GAIN_BIT];  // [R7] [R9]
                    end
                    // Gain byte: gain bits 7:0, one address per axis
                    if (gain_axis(reg_addr) == g)
                    begin
                        gain_value[g][7:0] <= reg_wdata;            // [R7] [R9]
                    end
                end
            end

            // Correction path for this axis
            acalt_axis_correct u_corr
            (
                .clk          (clk),
                .reset_n      (reset_n),
                .raw_valid    (raw_valid),
                .raw_value    (raw_xyz[g*16 +: 16]),
                .offset_value (offset_value[g]),
                .gain_value   (gain_value[g]),
                .out_valid    (axis_valid[g]),
                .out_value    (axis_out[g*16 +: 16])
            );
        end
    endgenerate

    // Read mux; calibration registers read back so software can do
    // read-modify-write on the shared high bytes
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `ACALT_ADDR_MODE_CTRL:
            begin
                // Only the mode field exists; the rest reads zero
                next_rdata = {5'h00, operating_mode_field};
            end
            `ACALT_ADDR_STARTUP_TWO:
            begin
                next_rdata = startup_config_two;
            end
            `ACALT_ADDR_SAMPLE_COUNT:
            begin
                next_rdata = oneshot_sample_count;
            end
            default:
            begin
                if (off_low_axis(reg_addr) != 2'd3)
                begin
                    // Offset low byte
                    next_rdata = offset_value[off_low_axis(reg_addr)][7:0];       // [R8]
                end
                else if (off_high_axis(reg_addr) != 2'd3)
                begin
                    // Shared byte: gain bit 8 over offset bits 14:8
                    next_rdata = {gain_value[off_high_axis(reg_addr)][8],
                                  offset_value[off_high_axis(reg_addr)][14:8]};   // [R8]
                end
                else if (gain_axis(reg_addr) != 2'd3)
                begin
                    // Gain low byte
                    next_rdata = gain_value[gain_axis(reg_addr)][7:0];            // [R8]
                end
                // Unmapped addresses keep the zero set above
            end
        endcase
    end

    // Read data register; unmapped addresses read zero
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                // Held until the next read, so a slow host can still take it
                reg_rdata <= next_rdata;
            end
        end
    end

    // A run starts when the mode field enters the trigger mode with a
    // non-zero count. A count of 255 runs until the mode field changes;
    // any other count stops after that many capture pulses.
    // One-shot sequencer
    acalt_trigger_seq u_seq
    (
        .clk          (clk),
        .reset_n      (reset_n),
        .mode         (operating_mode_field),
        .sample_count (oneshot_sample_count),
        .sample_tick  (sample_tick),
        .sample_req   (seq_req),
        .busy         (seq_busy)
    );

    // Latency, in clock edges after the edge that takes the request:
    //   register write   visible one edge later
    //   register read    data and valid one edge later
    //   sample tick      capture pulse two edges later
    //   raw sample       corrected result two edges later
    // The retiming stage below costs one cycle on the last two paths
    // and keeps every port of this block on a flop.
    // Retime sequencer and correction results so every output is a flop
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sample_req           <= 1'b0;
            trigger_busy         <= 1'b0;
            ext_valid            <= 1'b0;
            extended_output_regs <= 48'h000000000000;
        end
        else
        begin
            sample_req   <= seq_req;                 // [R2] [R3]
            trigger_busy <= seq_busy;
            ext_valid    <= axis_valid[0];
            if (axis_valid[0])
            begin
                // All axes share raw_valid, so the X strobe stands for all
                extended_output_regs <= axis_out;    // [R4]
            end
        end
    end

endmodule // acalt_regs

//--- rtl/acalt_trigger_seq.v
// One-shot trigger sample counter
`timescale 1ns/100ps
`include "acalt_defs.vh"
module acalt_trigger_seq
(
    input  wire       clk,          // System clock
    input  wire       reset_n,      // Async reset, active low
    input  wire [2:0] mode,         // Operating mode field
    input  wire [7:0] sample_count, // Samples per trigger
    input  wire       sample_tick,  // Sample-rate tick from the engine
    output reg        sample_req,   // Capture one sample, one-cycle pulse
    output reg        busy          // Trigger run in progress
);

    localparam ST_IDLE = 2'd0;      // Waiting for trigger mode entry
    localparam ST_RUN  = 2'd1;      // Counting samples
    localparam ST_DONE = 2'd2;      // Finished, wait for mode to leave trigger

    reg  [1:0] state;               // Sequencer state
    reg  [7:0] remaining;           // Samples still to take
    reg        endless;             // Count was 255 at start
    wire       oneshot_trigger_mode = (mode == `ACALT_MODE_TRIGGER); // Trigger mode selected

    // Entry into trigger mode starts a run; leaving the mode aborts it
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state      <= ST_IDLE;
            remaining  <= 8'h00;
            endless    <= 1'b0;
            sample_req <= 1'b0;
            busy       <= 1'b0;
        end
        else
        begin
            sample_req <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    // A count of zero is outside the legal range and starts nothing
                    if (oneshot_trigger_mode && sample_count != `ACALT_COUNT_NONE)
                    begin
                        state     <= ST_RUN;
                        busy      <= 1'b1;
                        remaining <= sample_count;                          // [R2]
                        endless   <= (sample_count == `ACALT_COUNT_ENDLESS); // [R3]
                    end
                end
                ST_RUN:
                begin
                    if (!oneshot_trigger_mode)
                    begin
                        state <= ST_IDLE;                  // [R3]
                        busy  <= 1'b0;
                    end
                    else if (sample_tick)
                    begin
                        sample_req <= 1'b1;
                        if (!endless)
                        begin
                            remaining <= remaining - 8'h01; // [R2]
                            if (remaining == 8'h01)
                            begin
                                state <= ST_DONE;
                                busy  <= 1'b0;
                            end
                        end
                    end
                end
                ST_DONE:
                begin
                    // Re-arm only after software leaves and re-enters trigger mode
                    if (!oneshot_trigger_mode)
                        state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

endmodule // acalt_trigger_seq

//--- verif/acalt_regs_sva.sv
// Checker for the calibration and trigger register bank
`timescale 1ns/100ps
module acalt_regs_chk
(
    input wire       clk,                  // System clock
    input wire       reset_n,              // Async reset, active low
    input wire       reg_wr,               // Write strobe
    input wire       reg_rd,               // Read strobe
    input wire [7:0] reg_addr,             // Register address
    input wire [7:0] reg_wdata,            // Write data
    input wire       sample_tick,          // Engine tick
    input wire       raw_valid,            // Raw sample strobe
    input wire [7:0] reg_rdata,            // Read data
    input wire       reg_rvalid,           // Read data valid
    input wire [2:0] operating_mode_field, // Current mode
    input wire [7:0] startup_config_two,   // Startup register
    input wire       sample_req,           // Capture pulse
    input wire       trigger_busy,         // Run in progress
    input wire       ext_valid             // Corrected sample strobe
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid without a read");
    startup_store_a: assert property (reg_wr && reg_addr == 8'h28
        |=> startup_config_two == $past(reg_wdata)) else $error("startup write lost");
    mode_store_a: assert property (reg_wr && reg_addr == 8'h10
        |=> {5'h00, operating_mode_field} == ($past(reg_wdata) & 8'h07))
        else $error("mode field not bits 2:0");
    mode_hold_a: assert property (!(reg_wr && reg_addr == 8'h10)
        |=> $stable(operating_mode_field)) else $error("mode changed without write");
    ext_delay_a: assert property (raw_valid |-> ##2 ext_valid)
        else $error("corrected sample late");
    ext_cause_a: assert property (ext_valid |-> $past(raw_valid, 2))
        else $error("corrected sample without raw");
    req_tick_a: assert property (sample_req |-> $past(sample_tick, 2))
        else $error("capture without tick");
    busy_mode_a: assert property (trigger_busy && operating_mode_field != 3'h6
        |-> ##[1:2] !trigger_busy) else $error("run outlived mode change");
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h40
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");

    // Main scenarios reached
    cover property (sample_req);
    cover property (ext_valid);
    cover property (trigger_busy ##1 !trigger_busy);
endmodule // acalt_regs_chk

bind acalt_regs acalt_regs_chk acalt_regs_chk_inst
(
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .sample_tick(sample_tick),
    .raw_valid(raw_valid), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .operating_mode_field(operating_mode_field),
    .startup_config_two(startup_config_two), .sample_req(sample_req),
    .trigger_busy(trigger_busy), .ext_valid(ext_valid)
);

//--- verif/test_axis_calibration_trigger_regs.sv
// Self-checking bench for the calibration and trigger register bank
`timescale 1ns/100ps
module test_axis_calibration_trigger_regs;
    reg         clk, reset_n;                    // Clock and active-low reset
    reg         reg_wr, reg_rd, trim_load;       // Register port strobes
    reg         sample_tick, raw_valid;          // Engine side strobes
    reg  [7:0]  reg_addr, reg_wdata, d;          // Register port data
    reg  [71:0] trim_data;                       // Factory trim word
    reg  [47:0] raw_xyz;                         // Raw results
    reg  [23:0] t;                               // One axis of trim
    wire [7:0]  reg_rdata, startup_config_two;   // Read data, startup content
    wire [2:0]  operating_mode_field;            // Mode field
    wire [47:0] extended_output_regs;            // Corrected results
    wire        reg_rvalid, sample_req, trigger_busy, ext_valid;
    integer     fails, compares, cycles, nreq, i;

    acalt_regs acalt_regs_inst (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .trim_load(trim_load), .trim_data(trim_data), .sample_tick(sample_tick),
        .raw_valid(raw_valid), .raw_xyz(raw_xyz), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .operating_mode_field(operating_mode_field),
        .startup_config_two(startup_config_two), .sample_req(sample_req),
        .trigger_busy(trigger_busy), .ext_valid(ext_valid),
        .extended_output_regs(extended_output_regs));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Capture pulses counted here; the cycle ceiling cuts a hang short
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (sample_req === 1'b1)
            nreq = nreq + 1;
        if (cycles == 10000)
        begin
            fails = fails + 1;
            complete_run;
        end
    end

    task chk(input string nm, input [47:0] exp, input [47:0] got);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    end
    endtask

    // One write, taken at the second edge
    task wr(input [7:0] a, input [7:0] v);
    begin
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    end
    endtask

    // One read; data and valid appear just after the taking edge
    task rd(input [7:0] a, output [7:0] v);
    begin
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("read valid", 48'h1, {47'h0, reg_rvalid});
        v = reg_rdata;
    end
    endtask

    // Ticks spaced wide enough that each request lands before the next
    task ticks(input integer n);
    begin
        repeat (n)
        begin
            @(posedge clk);
            sample_tick <= 1'b1;
            @(posedge clk);
            sample_tick <= 1'b0;
            repeat (3) @(posedge clk);
        end
        #1;
    end
    endtask

    // Leave trigger mode, set the count, re-enter, then count requests
    task count_run(input [7:0] c, input integer n, input integer e);
    begin
        wr(8'h10, 8'h00);
        wr(8'h29, c);
        wr(8'h10, 8'h06);
        nreq = 0;
        repeat (2) @(posedge clk);
        ticks(n);
        chk("sample requests", e, nreq);
    end
    endtask

    task complete_run;
    begin
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    initial
    begin
        {reg_wr, reg_rd, trim_load, sample_tick, raw_valid} = 5'h00;
        {reg_addr, reg_wdata, trim_data, raw_xyz} = 136'h0;
        {fails, compares, cycles, nreq} = 0;
        reset_n = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        wr(8'h28, 8'h00);
        rd(8'h28, d); chk("startup read", 8'h00, d);
        chk("startup output", 48'h0, {40'h0, startup_config_two});
        rd(8'h29, d); chk("count reset", 8'h00, d);
        // Trim arrives as {gain,offset} per axis, X lowest
        trim_data <= {9'h155, 15'h4321, 9'h0F0, 15'h7ABC, 9'h1A5, 15'h1234};
        @(posedge clk); trim_load <= 1'b1;
        @(posedge clk); trim_load <= 1'b0;
        for (i = 0; i < 3; i = i + 1)
        begin
            t = trim_data[24 * i +: 24];
            rd(8'h2A + 2 * i, d); chk("offset low", t[7:0], d);
            rd(8'h2B + 2 * i, d); chk("offset high", {t[23], t[14:8]}, d);
            rd(8'h30 + i, d); chk("gain low", t[22:15], d);
        end
        // Software write replaces trim; gain msb flipped by read-modify-write
        wr(8'h2A, 8'h5A);
        rd(8'h2B, d);
        wr(8'h2B, d ^ 8'h80);
        rd(8'h2B, t[7:0]); chk("shared high", d ^ 8'h80, t[7:0]);
        rd(8'h2A, d); chk("offset replaced", 8'h5A, d);
        rd(8'h30, d); chk("gain untouched", 8'hA5, d);
        wr(8'h40, 8'hAA);
        rd(8'h40, d); chk("unmapped read", 8'h00, d);
        wr(8'h10, 8'hF9);
        #1;
        chk("mode field", 48'h1, {45'h0, operating_mode_field});
        // X +100 unity, Y -50 unity, Z 0 half gain
        wr(8'h2A, 8'h64); wr(8'h2B, 8'h80); wr(8'h30, 8'h00);
        wr(8'h2C, 8'hCE); wr(8'h2D, 8'hFF); wr(8'h31, 8'h00);
        wr(8'h2E, 8'h00); wr(8'h2F, 8'h00); wr(8'h32, 8'h80);
        @(posedge clk);
        raw_xyz <= {16'd400, -16'd200, 16'd1000};
        raw_valid <= 1'b1;
        @(posedge clk); raw_valid <= 1'b0;
        @(posedge clk); #1;
        chk("corrected valid", 48'h1, {47'h0, ext_valid});
        chk("corrected xyz", {16'd200, -16'd250, 16'd1100}, extended_output_regs);
        count_run(8'd1, 3, 1);
        count_run(8'd254, 256, 254);
        count_run(8'd0, 2, 0);
        count_run(8'd255, 6, 6);
        chk("endless busy", 48'h1, {47'h0, trigger_busy});
        wr(8'h10, 8'h00);
        nreq = 0;
        ticks(2);
        chk("after stop", 48'h0, nreq);
        chk("stopped busy", 48'h0, {47'h0, trigger_busy});
        complete_run;
    end
endmodule // test_axis_calibration_trigger_regs
